/* File: dv/sbsp_host_model.sv */
/*
  Bus master model: resolves the shared data pins of the memory port.
  Assumes the bench supplies the master's write data and drive enable.
*/
`default_nettype none

module sbsp_host_model #(
  parameter int W = 36
) (
  input wire logic sys_clk,
  input wire logic [W-1:0] dev_q,
  input wire logic dev_oe,
  input wire logic drv,
  input wire logic [W-1:0] drv_q,
  output logic [W-1:0] bus
);
  logic [W-1:0] last_ff;
  // A released bus shows the inverse of its last value, so stale data never matches.
  always_comb begin
    bus = ~last_ff;
    if (dev_oe) begin
      bus = dev_q;
    end else if (drv) begin
      bus = drv_q;
    end
  end
  always_ff @(posedge sys_clk) begin
    last_ff <= bus;
  end
endmodule : sbsp_host_model

`default_nettype wire

/* File: dv/test_sync_burst_sram_port.sv */
/*
  Self-checking bench for the burst memory port.
  Assumes the package, the port and the master model compile first.
*/
`default_nettype none

module test_sync_burst_sram_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam sbsp_pkg::sbsp_ctl_t idle_ctl = sbsp_pkg::sbsp_ctl_t'(11'h2FC);
  logic sys_clk, rst_n, hd, dev_oe, sleeping, oe_n_v, ord_v;
  sbsp_pkg::sbsp_ctl_t ctl, c;
  logic [5:0] addr_in;
  logic [3:0] sel, sel_n;
  logic [35:0] hq, bus, dev_q;
  logic [35:0] d [4];
  int bad_count, checks_done;

  sbsp_port #(.ADDR_W(6), .LANES(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ctl(ctl),
    .addr_in(addr_in), .byte_lane_select_n(sel_n), .data_in(bus), .data_out(dev_q),
    .data_oe(dev_oe), .sleeping(sleeping));
  sbsp_host_model #(.W(36)) host (.sys_clk(sys_clk), .dev_q(dev_q), .dev_oe(dev_oe),
    .drv(hd), .drv_q(hq), .bus(bus));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Every request is launched on a rising edge and held until the next one.
  task automatic go(input logic [5:0] a, input logic h, input logic [35:0] q);
    @(posedge sys_clk);
    c.output_enable_n = oe_n_v;
    c.burst_order_sel = ord_v;
    ctl <= c;
    addr_in <= a;
    sel_n <= sel;
    hd <= h;
    hq <= q;
    c = idle_ctl;
    sel = 4'hF;
  endtask : go

  task automatic tick;
    go(6'h00, 1'b0, 36'h0);
    #1;
  endtask : tick

  task automatic t_write;
    for (int i = 0; i < 4; i++) begin
      c.ctrl_addr_strobe_n = 1'b0;
      c.global_write_n = 1'b0;
      c.byte_write_enable_n = 1'b0;
      go(6'h10 + 6'(i), 1'b1, d[i]);
    end
  endtask : t_write

  task automatic t_burst(input logic ord);
    logic [1:0] k;
    c.ctrl_addr_strobe_n = 1'b0;
    c.chip_select_second = 1'b0;
    go(6'h00, 1'b0, 36'h0);
    ord_v = ord;
    oe_n_v = 1'b0;
    c.ctrl_addr_strobe_n = 1'b0;
    go(6'h11, 1'b0, 36'h0);
    // Four steps walk the whole wrapping burst and come back to the first word.
    for (int j = 0; j < 6; j++) begin
      c.burst_step_n = (j > 3);
      tick();
      k = 2'(j > 4 ? 4 : j);
      k = ord ? (2'h1 ^ k) : (2'h1 + k);
      chk(dev_q, d[k]);
      chk(36'(dev_oe), 36'(j > 0));
    end
    c.ctrl_addr_strobe_n = 1'b0;
    c.chip_select_second = 1'b0;
    tick();
    tick();
    chk(36'(dev_oe), 36'h1);
    tick();
    chk(36'(dev_oe), 36'h0);
    oe_n_v = 1'b1;
  endtask : t_burst

  task automatic t_strobes;
    c.proc_addr_strobe_n = 1'b0;
    c.ctrl_addr_strobe_n = 1'b0;
    c.global_write_n = 1'b0;
    go(6'h12, 1'b1, 36'hF_FFFF_FFFF);
    tick();
    tick();
    chk(dev_q, d[2]);
    c.proc_addr_strobe_n = 1'b0;
    c.chip_select_primary_n = 1'b1;
    go(6'h13, 1'b0, 36'h0);
    tick();
    tick();
    chk(dev_q, d[2]);
    c.ctrl_addr_strobe_n = 1'b0;
    c.byte_write_enable_n = 1'b0;
    sel = 4'hE;
    go(6'h12, 1'b1, 36'hF_FFFF_FFFF);
    c.ctrl_addr_strobe_n = 1'b0;
    go(6'h12, 1'b0, 36'h0);
    tick();
    tick();
    chk(dev_q, {d[2][35:9], 9'h1FF});
  endtask : t_strobes

  task automatic t_sleep;
    oe_n_v = 1'b0;
    tick();
    tick();
    chk(36'(dev_oe), 36'h1);
    c.sleep_request = 1'b1;
    tick();
    c.sleep_request = 1'b1;
    tick();
    chk(36'(sleeping), 36'h1);
    chk(36'(dev_oe), 36'h0);
    tick();
    chk(36'(sleeping), 36'h1);
    c.ctrl_addr_strobe_n = 1'b0;
    go(6'h12, 1'b0, 36'h0);
    tick();
    tick();
    chk(dev_q, {d[2][35:9], 9'h1FF});
    chk(36'(sleeping), 36'h0);
  endtask : t_sleep

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // Fifty or so cycles are needed; the limit leaves ample margin.
  initial begin
    repeat (1000) @(posedge sys_clk);
    bad_count++;
    test_done();
  end

  initial begin
    ctl = idle_ctl;
    c = idle_ctl;
    addr_in = 6'h00;
    sel = 4'hF;
    sel_n = 4'hF;
    hd = 1'b0;
    hq = 36'h0;
    oe_n_v = 1'b1;
    ord_v = 1'b0;
    rst_n = 1'b0;
    bad_count = 0;
    checks_done = 0;
    d = '{36'h9_1357_9BDF, 36'h0_2468_ACE0, 36'h8_F0E1_D2C3, 36'h1_B4A5_9687};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk(dev_q, 36'h0);
    chk(36'(dev_oe), 36'h0);
    t_write();
    t_burst(1'b0);
    t_burst(1'b1);
    t_strobes();
    t_sleep();
    test_done();
  end
endmodule : test_sync_burst_sram_port

`default_nettype wire

/* File: hw/sbsp_pkg.sv */
/*
  Shared types and constants for the synchronous burst memory port.
  Assumes a single clock domain and a bus master that drives the memory pins.
*/
`default_nettype none

package sbsp_pkg;

  // Byte lane shape: eight data bits plus one parity bit.
  localparam int LANE_DATA_W = 8;
  localparam int LANE_PAR_W = 1;
  localparam int LANE_W = LANE_DATA_W + LANE_PAR_W;
  localparam int LANES_DEF = 4;
  localparam int ADDR_W_DEF = 20;

  // Burst counter width and its value on a fresh address.
  localparam int CNT_W = 2;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] CNT_STEP = 2'h1;

  // Burst order strap encoding.
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // Port states, Gray coded along deselect, select, sleep.
  typedef enum logic [1:0] {
    SBSP_DESEL = 2'b00,
    SBSP_SEL = 2'b01,
    SBSP_SLEEP = 2'b11
  } sbsp_state_t;

  // Synchronous control pins, sampled on every rising edge.
  typedef struct packed {
    logic chip_select_primary_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic output_enable_n;
    logic burst_order_sel;
    logic sleep_request;
  } sbsp_ctl_t;

endpackage : sbsp_pkg

`default_nettype wire

/* File: hw/sbsp_port.sv */
/*
  Synchronous burst memory: registered control capture, two address strobes,
  a two-bit wrapping burst counter, byte lanes with parity and a pipelined read.
  Assumes one clock, inputs synchronous to it, and an external resolver for the
  shared data pins built from data_out, data_oe and data_in.
*/
// Notes on behaviour
// - All synchronous inputs captured on rising edge.
// - Low step input advances burst address once.
// - Three chip selects decide selection, primary low.
// - Processor strobe ignored while primary select high.
// - Output enable low drives pins, high floats.
// - First read after deselect keeps pins floating.
// - Processor strobe loads address and burst counter.
// - Controller strobe loads address and burst counter.
// - Both strobes low: processor strobe wins.
// - Strap low linear, high interleaved burst order.
// - Sleep request idles port, contents retained.
// - Input data captured on rising edge.
// - Read data from address of previous edge.
// - Each lane is eight data plus parity.
// - Global write writes all lanes regardless.
// - Two-bit counter wraps over four locations.
// - Deselect floats outputs after the next edge.
`default_nettype none

module sbsp_port #(
  parameter int ADDR_W = sbsp_pkg::ADDR_W_DEF,
  parameter int LANES = sbsp_pkg::LANES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire sbsp_pkg::sbsp_ctl_t ctl,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic [LANES*sbsp_pkg::LANE_W-1:0] data_in,
  output logic [LANES*sbsp_pkg::LANE_W-1:0] data_out,
  output logic data_oe,
  output logic sleeping
);

  localparam int DW = LANES * sbsp_pkg::LANE_W;

  typedef struct packed {
    sbsp_pkg::sbsp_state_t st;
    logic [ADDR_W-1:0] addr;
    logic [1:0] cnt;
    logic mode;
    logic oe;
    logic [DW-1:0] dout;
    logic slp;
  } sbsp_regs_t;

  sbsp_regs_t r_ff;
  sbsp_regs_t nxt_r;
  logic [DW-1:0] mem [0:(1<<ADDR_W)-1];

  logic sel;
  logic proc_go;
  logic ctrl_go;
  logic start;
  logic wr_req;
  logic wr_go;
  logic rd_go;
  logic first_rd;
  logic [LANES-1:0] lane_we;
  logic [1:0] low_bits;
  logic [ADDR_W-1:0] acc_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Address strobes and write qualification.

  always_comb begin
    sel = !ctl.chip_select_primary_n && ctl.chip_select_second && !ctl.chip_select_third_n;
    proc_go = !ctl.proc_addr_strobe_n && !ctl.chip_select_primary_n && !ctl.sleep_request;
    ctrl_go = !ctl.ctrl_addr_strobe_n && !proc_go && !ctl.sleep_request;
    start = proc_go || ctrl_go;
    wr_req = !ctl.global_write_n || (!ctl.byte_write_enable_n && !(&byte_lane_select_n));
    if (!ctl.global_write_n) begin
      lane_we = '1;
    end else if (!ctl.byte_write_enable_n) begin
      lane_we = ~byte_lane_select_n;
    end else begin
      lane_we = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Every access, read or write, uses the next effective address,
  // so a step and its access land on the same word.

  always_comb begin
    nxt_r = r_ff;
    nxt_r.mode = ctl.burst_order_sel;
    wr_go = 1'b0;
    rd_go = 1'b0;
    first_rd = 1'b0;
    case (r_ff.st)
      sbsp_pkg::SBSP_DESEL, sbsp_pkg::SBSP_SEL: begin
        if (ctl.sleep_request) begin
          nxt_r.st = sbsp_pkg::SBSP_SLEEP;
        end else if (start && !sel) begin
          nxt_r.st = sbsp_pkg::SBSP_DESEL;
        end else if (start) begin
          nxt_r.st = sbsp_pkg::SBSP_SEL;
          nxt_r.addr = addr_in;
          nxt_r.cnt = sbsp_pkg::CNT_RST;
          first_rd = (r_ff.st == sbsp_pkg::SBSP_DESEL);
          // A processor-strobe cycle ignores the write pins.
          wr_go = ctrl_go && wr_req;
          rd_go = !wr_go;
        end else if (r_ff.st == sbsp_pkg::SBSP_SEL) begin
          if (!ctl.burst_step_n) begin
            nxt_r.cnt = r_ff.cnt + sbsp_pkg::CNT_STEP;
          end
          wr_go = wr_req;
          rd_go = !wr_req;
        end
      end
      sbsp_pkg::SBSP_SLEEP: begin
        if (!ctl.sleep_request) begin
          nxt_r.st = sbsp_pkg::SBSP_DESEL;
        end
      end
      default: begin
        nxt_r.st = sbsp_pkg::SBSP_DESEL;
      end
    endcase
    if (nxt_r.mode == sbsp_pkg::ORDER_INTERLEAVED) begin
      low_bits = nxt_r.addr[1:0] ^ nxt_r.cnt;
    end else begin
      low_bits = nxt_r.addr[1:0] + nxt_r.cnt;
    end
    acc_addr = {nxt_r.addr[ADDR_W-1:2], low_bits};
    if (rd_go) begin
      nxt_r.dout = mem[acc_addr];
      nxt_r.oe = !ctl.output_enable_n && !first_rd;
    end else if (start && !sel && !ctl.sleep_request && r_ff.st == sbsp_pkg::SBSP_SEL) begin
      // Double-cycle deselect: the last word stays one more cycle.
      // Only the edge that leaves the selected state may hold it, or a run of
      // deselects would keep the pins driven for ever.
      nxt_r.oe = r_ff.oe && !ctl.output_enable_n;
    end else begin
      nxt_r.oe = 1'b0;
    end
    // Registered so that the sleep indication comes straight from a flop.
    nxt_r.slp = (nxt_r.st == sbsp_pkg::SBSP_SLEEP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and storage. The array has no reset so contents survive sleep.

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '{st: sbsp_pkg::SBSP_DESEL, addr: '0, cnt: sbsp_pkg::CNT_RST,
                mode: sbsp_pkg::ORDER_LINEAR, oe: 1'b0, dout: '0, slp: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (wr_go && lane_we[i]) begin
        mem[acc_addr][i*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W] <=
          data_in[i*sbsp_pkg::LANE_W +: sbsp_pkg::LANE_W];
      end
    end
  end

  assign data_out = r_ff.dout;
  assign data_oe = r_ff.oe;
  assign sleeping = r_ff.slp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_proc_ignored;
    (!ctl.proc_addr_strobe_n && ctl.chip_select_primary_n && ctl.ctrl_addr_strobe_n
     && !ctl.sleep_request) |=> $stable(r_ff.addr);
  endproperty
  a_proc_ignored: assert property (p_proc_ignored) else $error("processor strobe not ignored");

  property p_proc_load;
    (!ctl.proc_addr_strobe_n && !ctl.chip_select_primary_n && sel && !ctl.sleep_request
     && r_ff.st != sbsp_pkg::SBSP_SLEEP)
      |=> r_ff.addr == $past(addr_in) && r_ff.cnt == sbsp_pkg::CNT_RST;
  endproperty
  a_proc_load: assert property (p_proc_load) else $error("processor strobe load wrong");

  property p_ctrl_load;
    (!ctl.ctrl_addr_strobe_n && ctl.proc_addr_strobe_n && sel && !ctl.sleep_request
     && r_ff.st != sbsp_pkg::SBSP_SLEEP)
      |=> r_ff.addr == $past(addr_in) && r_ff.cnt == sbsp_pkg::CNT_RST;
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("controller strobe load wrong");

  property p_both_strobes;
    (!ctl.proc_addr_strobe_n && !ctl.ctrl_addr_strobe_n && !ctl.chip_select_primary_n
     && !ctl.sleep_request) |-> proc_go && !ctrl_go && !wr_go;
  endproperty
  a_both_strobes: assert property (p_both_strobes) else $error("strobe priority wrong");

  property p_step;
    (r_ff.st == sbsp_pkg::SBSP_SEL && !start && !ctl.burst_step_n && !ctl.sleep_request)
      |=> r_ff.cnt == $past(r_ff.cnt) + sbsp_pkg::CNT_STEP;
  endproperty
  a_step: assert property (p_step) else $error("burst counter did not step");

  property p_order;
    rd_go |-> acc_addr[1:0] == (nxt_r.mode ? (nxt_r.addr[1:0] ^ nxt_r.cnt)
                                           : 2'(nxt_r.addr[1:0] + nxt_r.cnt));
  endproperty
  a_order: assert property (p_order) else $error("burst order wrong");

  property p_first_read;
    (r_ff.st == sbsp_pkg::SBSP_DESEL && start && sel && !ctl.sleep_request) |=> !data_oe;
  endproperty
  a_first_read: assert property (p_first_read) else $error("output drove on first read");

  property p_oe_cause;
    data_oe |-> !$past(ctl.output_enable_n);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive without output enable");

  property p_deselect;
    (start && !sel && !ctl.sleep_request) ##1 (!start || !sel) |=> !data_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("outputs not floated after deselect");

  property p_sleep;
    ctl.sleep_request |=> !data_oe && sleeping;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not idle port");

  property p_global;
    (wr_go && !ctl.global_write_n) |-> &lane_we ##1 (mem[$past(acc_addr)] == $past(data_in));
  endproperty
  a_global: assert property (p_global) else $error("global write missed a lane");

  property p_read_data;
    rd_go |=> data_out == $past(mem[acc_addr]);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not from accessed word");

  property p_wrap;
    (r_ff.st == sbsp_pkg::SBSP_SEL && !start && !ctl.burst_step_n && !ctl.sleep_request
     && &r_ff.cnt) |=> r_ff.cnt == sbsp_pkg::CNT_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("burst counter did not wrap");

  property p_write_float;
    wr_go |=> !data_oe;
  endproperty
  a_write_float: assert property (p_write_float) else $error("pins drove during a write");

  property p_byte_lanes;
    (wr_go && ctl.global_write_n)
      |-> !ctl.byte_write_enable_n && lane_we == ~byte_lane_select_n;
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes written wrongly");

  property p_mode;
    1'b1 |=> r_ff.mode == $past(ctl.burst_order_sel);
  endproperty
  a_mode: assert property (p_mode) else $error("burst order strap not captured");

  property p_sleep_hold;
    (sleeping && ctl.sleep_request) |=> sleeping && $stable(r_ff.addr) && !data_oe;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep state not held");

  property p_wake;
    (sleeping && !ctl.sleep_request) |=> r_ff.st == sbsp_pkg::SBSP_DESEL && !sleeping;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not return to deselect");

  property p_desel_state;
    (start && !sel && !ctl.sleep_request && r_ff.st != sbsp_pkg::SBSP_SLEEP)
      |=> r_ff.st == sbsp_pkg::SBSP_DESEL;
  endproperty
  a_desel_state: assert property (p_desel_state) else $error("deselect not taken");

  property p_proc_no_write;
    (proc_go && sel && r_ff.st != sbsp_pkg::SBSP_SLEEP) |-> !wr_go && rd_go;
  endproperty
  a_proc_no_write: assert property (p_proc_no_write) else $error("processor strobe wrote");

  ////////////////////////////////////////////////////////////////////////////
  // Cover points for the main scenarios.

  c_read: cover property (rd_go ##1 data_oe);
  c_burst: cover property (start ##1 !ctl.burst_step_n [*3]);
  c_write: cover property (wr_go && !ctl.byte_write_enable_n);
  c_sleep: cover property (sleeping ##1 !sleeping);
  c_deselect: cover property ((start && !sel) ##1 data_oe);

endmodule : sbsp_port

`default_nettype wire
